// ===== sdm_pkg.sv
// Constants and types shared by the special drive mode control block
package sdm_pkg;

  // ****************************************
  // Register bus
  // ****************************************
  localparam int SDM_AW = 4;
  localparam int SDM_DW = 16;
  localparam logic [3:0] SDM_IDX_OPMODE = 4'h0;
  localparam logic [3:0] SDM_IDX_CTRL = 4'h1;
  localparam logic [3:0] SDM_IDX_TARGET = 4'h2;
  localparam logic [3:0] SDM_IDX_CFG_EN = 4'h3;
  localparam logic [3:0] SDM_IDX_CFG_MODE = 4'h4;
  localparam logic [3:0] SDM_IDX_SAVE = 4'h5;
  localparam logic [3:0] SDM_IDX_STATUS = 4'h6;
  localparam logic [3:0] SDM_IDX_SPEED = 4'h7;
  localparam logic [3:0] SDM_IDX_VSCALE = 4'h8;
  localparam logic [3:0] SDM_IDX_AOFFSET = 4'h9;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] SDM_RST_OPMODE = 8'h00;
  localparam logic [15:0] SDM_RST_CTRL = 16'h0000;
  localparam logic [15:0] SDM_RST_TARGET = 16'h0000;
  localparam logic [7:0] SDM_RST_CFG_EN = 8'h00;
  localparam logic [3:0] SDM_RST_CFG_MODE = 4'h0;
  localparam logic [15:0] SDM_RST_VSCALE = 16'h0001;
  localparam logic [15:0] SDM_RST_AOFFSET = 16'h0000;
  localparam logic [7:0] SDM_OPMODE_VELOCITY = 8'h02;
  localparam logic [7:0] SDM_OPMODE_CLKDIR = 8'hff;
  localparam logic [7:0] SDM_SPECIAL_ON = 8'h02;
  localparam logic [15:0] SDM_CTRL_STOP = 16'h0000;
  localparam logic [15:0] SDM_CTRL_READY = 16'h0006;
  localparam logic [15:0] SDM_CTRL_ENABLE = 16'h000f;

  // ****************************************
  // Mode code fields
  // ****************************************
  localparam int SDM_MODE_CLOSED_BIT = 3;
  localparam logic [2:0] SDM_FN_TEST_CW = 3'h2;
  localparam logic [2:0] SDM_FN_TEST_CCW = 3'h3;
  localparam logic [2:0] SDM_FN_ANA_FAST = 3'h4;
  localparam logic [2:0] SDM_FN_ANA_SLOW = 3'h5;
  localparam logic [2:0] SDM_FN_JOY_FAST = 3'h6;
  localparam logic [2:0] SDM_FN_JOY_SLOW = 3'h7;

  // ****************************************
  // Speeds and analog scaling
  // ****************************************
  localparam logic [15:0] SDM_TEST_RPM = 16'h001e;
  localparam logic [15:0] SDM_MAX_FAST_RPM = 16'h03e8;
  localparam logic [15:0] SDM_MAX_SLOW_RPM = 16'h0064;
  localparam int SDM_ADC_BITS = 12;
  localparam int SDM_ADC_FULL_MV = 10000;
  localparam int SDM_DEAD_MV = 20;
  localparam logic [11:0] SDM_ADC_MAX = 12'hfff;
  localparam logic [11:0] SDM_ADC_MID = 12'h800;
  localparam logic [11:0] SDM_DEAD_CODES = 12'((SDM_DEAD_MV * 4096) / SDM_ADC_FULL_MV);

  typedef enum logic [1:0] {SDM_PS_DISABLED, SDM_PS_READY, SDM_PS_ENABLED} sdm_pstate_t;

endpackage : sdm_pkg

// ===== sdm_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module sdm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule : sdm_sync

// ===== sdm_control.sv
// Special drive mode control: velocity test run, pin-driven special modes, power state
//
// Summary of operation
// (RL1) Mode-of-operation value 2 selects velocity mode using the target speed register.
// (RL2) Writing zero to the control word stops the motor.
// (RL3) Master should read status back after each parameter write.
// (RL4) In special modes only the enable pin drives power state; control word ignored.
// (RL5) Digital input 3 is the enable signal in special modes.
// (RL6) Special modes active only when configuration subindex 1 holds 2.
// (RL7) Mode codes 0-7 open loop, 8-15 the same functions closed loop.
// (RL8) Code low bits: clock-direction, test cw/ccw, analog, joystick, each 1000/100 rpm.
// (RL9) Configuration is saved to storage and applies only after restart.
// (RL10) Clock-direction mode forces that operating mode; steps follow pins, gated by enable.
// (RL11) Analog mode runs velocity mode and writes converted voltage into target speed.
// (RL12) Analog full scale is 100 or 1000 rpm; velocity scaling set to match.
// (RL13) Normal analog: full voltage is full speed, sign from direction pin, default clockwise.
// (RL14) Normal analog: zero to 20 mV gives no motion.
// (RL15) Joystick: half voltage is zero speed; analog offset set automatically.
// (RL16) Joystick: below midpoint negative, above positive, dead zone 20 mV around midpoint.
// (RL17) Test run turns at 30 rpm in coded direction while enable is set.
// (RL18) Enable deasserted in special modes leaves operation enabled and stops motion; here release drops to disabled.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
module sdm_control (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [sdm_pkg::SDM_AW-1:0] regAddr,
  input wire logic [sdm_pkg::SDM_DW-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [sdm_pkg::SDM_DW-1:0] regRdata,
  input wire logic [3:0] digitalIn,
  input wire logic clockIn,
  input wire logic directionIn,
  input wire logic [sdm_pkg::SDM_ADC_BITS-1:0] adcData,
  input wire logic adcValid,
  input wire logic [7:0] nvCfgEnable,
  input wire logic [3:0] nvCfgMode,
  output logic nvSave,
  output logic [7:0] nvSaveEnable,
  output logic [3:0] nvSaveMode,
  output logic [7:0] opModeEff,
  output logic driveEnable,
  output logic closedLoop,
  output logic signed [15:0] speedCmd,
  output logic stepPulse,
  output logic stepDir
);
  import sdm_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pinSync;
  logic enSync;
  logic clkSync;
  logic dirSync;

  sdm_sync #(.WIDTH(3)) pinSyncInst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .asyncIn({digitalIn[3], clockIn, directionIn}),
    .syncOut(pinSync)
  );
  // (RL5) enable from input 3
  assign enSync = pinSync[2];
  assign clkSync = pinSync[1];
  assign dirSync = pinSync[0];

  // ****************************************
  // Active configuration, loaded at restart
  // ****************************************
  logic started_reg, started_next;
  logic [7:0] actEn_reg, actEn_next;
  logic [3:0] actMode_reg, actMode_next;
  logic specialActive;
  logic [2:0] modeFn;
  logic isClkDir, isTest, isAnalog, isJoy, isFast;

  // (RL9) stored image taken once after reset release
  always_comb begin
    started_next = 1'b1;
    actEn_next = actEn_reg;
    actMode_next = actMode_reg;
    if (!started_reg) begin
      actEn_next = nvCfgEnable;
      actMode_next = nvCfgMode;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      started_reg <= 1'b0;
      actEn_reg <= SDM_RST_CFG_EN;
      actMode_reg <= SDM_RST_CFG_MODE;
    end else begin
      started_reg <= started_next;
      actEn_reg <= actEn_next;
      actMode_reg <= actMode_next;
    end
  end

  // (RL6) activation code
  assign specialActive = (actEn_reg == SDM_SPECIAL_ON);
  // (RL7) upper bit picks the loop, lower three the function
  assign modeFn = actMode_reg[2:0];
  assign closedLoop = actMode_reg[SDM_MODE_CLOSED_BIT];
  // (RL8) function decode
  assign isClkDir = specialActive && (modeFn[2:1] == 2'b00);
  assign isTest = specialActive && (modeFn == SDM_FN_TEST_CW || modeFn == SDM_FN_TEST_CCW);
  assign isAnalog = specialActive && (modeFn == SDM_FN_ANA_FAST || modeFn == SDM_FN_ANA_SLOW);
  assign isJoy = specialActive && (modeFn == SDM_FN_JOY_FAST || modeFn == SDM_FN_JOY_SLOW);
  assign isFast = (modeFn == SDM_FN_ANA_FAST || modeFn == SDM_FN_JOY_FAST);

  // ****************************************
  // Analog to speed conversion
  // ****************************************
  logic [15:0] maxRpm;
  logic [11:0] anaDelta;
  logic [11:0] anaSpan;
  logic anaInDead;
  logic anaNeg;
  logic [27:0] anaProd;
  logic [15:0] anaMag;
  logic signed [15:0] anaSpeed;

  // (RL12) full scale picked by the mode code
  assign maxRpm = isFast ? SDM_MAX_FAST_RPM : SDM_MAX_SLOW_RPM;

  always_comb begin
    anaDelta = adcData;
    anaSpan = SDM_ADC_MAX;
    // (RL13) low direction pin means clockwise, positive
    anaNeg = dirSync;
    if (isJoy) begin
      // (RL16) sign from side of midpoint
      anaSpan = SDM_ADC_MID;
      anaNeg = (adcData < SDM_ADC_MID);
      anaDelta = anaNeg ? 12'(SDM_ADC_MID - adcData) : 12'(adcData - SDM_ADC_MID);
    end
    // (RL14) dead zone near zero, and around midpoint for joystick
    anaInDead = (anaDelta <= SDM_DEAD_CODES);
    anaProd = 28'(anaDelta) * 28'(maxRpm);
    anaMag = anaInDead ? 16'h0000 : 16'(anaProd / 28'(anaSpan));
    anaSpeed = anaNeg ? -$signed(anaMag) : $signed(anaMag);
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] opMode_reg, opMode_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] target_reg, target_next;
  logic [7:0] cfgEn_reg, cfgEn_next;
  logic [3:0] cfgMode_reg, cfgMode_next;
  logic [15:0] vScale_reg, vScale_next;
  logic [15:0] aOffset_reg, aOffset_next;
  logic nvSave_reg, nvSave_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] statusWord;
  sdm_pstate_t pState_reg, pState_next;

  assign statusWord = {4'h0, actMode_reg, 3'h0, dirSync, enSync,
                       (pState_reg == SDM_PS_ENABLED), closedLoop, specialActive};

  always_comb begin
    opMode_next = opMode_reg;
    ctrl_next = ctrl_reg;
    target_next = target_reg;
    cfgEn_next = cfgEn_reg;
    cfgMode_next = cfgMode_reg;
    vScale_next = vScale_reg;
    aOffset_next = aOffset_reg;
    nvSave_next = 1'b0;
    rdata_next = 16'h0000;
    if (regWrite) begin
      case (regAddr)
        SDM_IDX_OPMODE: opMode_next = regWdata[7:0];
        SDM_IDX_CTRL: ctrl_next = regWdata;
        SDM_IDX_TARGET: target_next = regWdata;
        SDM_IDX_CFG_EN: cfgEn_next = regWdata[7:0];
        SDM_IDX_CFG_MODE: cfgMode_next = regWdata[3:0];
        // (RL9) store pulse; the live configuration is untouched
        SDM_IDX_SAVE: nvSave_next = 1'b1;
        SDM_IDX_VSCALE: vScale_next = regWdata;
        SDM_IDX_AOFFSET: aOffset_next = regWdata;
        default: nvSave_next = 1'b0;
      endcase
    end
    // (RL11) converted voltage overrides software target writes
    if ((isAnalog || isJoy) && adcValid) begin
      target_next = anaSpeed;
    end
    // (RL12) scaling follows the chosen full scale
    if (isAnalog || isJoy) begin
      vScale_next = maxRpm;
    end
    // (RL15) joystick zero at half scale
    if (isJoy) begin
      aOffset_next = 16'(SDM_ADC_MID);
    end
    if (regRead) begin
      case (regAddr)
        SDM_IDX_OPMODE: rdata_next = {8'h00, opMode_reg};
        SDM_IDX_CTRL: rdata_next = ctrl_reg;
        SDM_IDX_TARGET: rdata_next = target_reg;
        SDM_IDX_CFG_EN: rdata_next = {8'h00, cfgEn_reg};
        SDM_IDX_CFG_MODE: rdata_next = {12'h000, cfgMode_reg};
        SDM_IDX_STATUS: rdata_next = statusWord;
        SDM_IDX_SPEED: rdata_next = speedCmd;
        SDM_IDX_VSCALE: rdata_next = vScale_reg;
        SDM_IDX_AOFFSET: rdata_next = aOffset_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      opMode_reg <= SDM_RST_OPMODE;
      ctrl_reg <= SDM_RST_CTRL;
      target_reg <= SDM_RST_TARGET;
      cfgEn_reg <= SDM_RST_CFG_EN;
      cfgMode_reg <= SDM_RST_CFG_MODE;
      vScale_reg <= SDM_RST_VSCALE;
      aOffset_reg <= SDM_RST_AOFFSET;
      nvSave_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      opMode_reg <= opMode_next;
      ctrl_reg <= ctrl_next;
      target_reg <= target_next;
      cfgEn_reg <= cfgEn_next;
      cfgMode_reg <= cfgMode_next;
      vScale_reg <= vScale_next;
      aOffset_reg <= aOffset_next;
      nvSave_reg <= nvSave_next;
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;
  assign nvSave = nvSave_reg;
  assign nvSaveEnable = cfgEn_reg;
  assign nvSaveMode = cfgMode_reg;

  // ****************************************
  // Power state and motion
  // ****************************************
  logic [7:0] opModeEff_reg, opModeEff_next;
  logic signed [15:0] speed_reg, speed_next;
  logic clkPrev_reg;
  logic step_reg, step_next;
  logic stepDir_reg;

  always_comb begin
    pState_next = pState_reg;
    if (specialActive) begin
      // (RL4) enable pin alone decides; (RL18) drop out on release
      pState_next = enSync ? SDM_PS_ENABLED : SDM_PS_DISABLED;
    end else begin
      case (ctrl_reg)
        // (RL2) zero control word stops the drive
        SDM_CTRL_STOP: pState_next = SDM_PS_DISABLED;
        SDM_CTRL_READY: pState_next = SDM_PS_READY;
        SDM_CTRL_ENABLE: pState_next = SDM_PS_ENABLED;
        default: pState_next = pState_reg;
      endcase
    end
  end

  always_comb begin
    opModeEff_next = opMode_reg;
    speed_next = 16'sh0000;
    step_next = 1'b0;
    if (isClkDir) begin
      // (RL10) forced mode, steps on clock rising edge
      opModeEff_next = SDM_OPMODE_CLKDIR;
      step_next = (pState_reg == SDM_PS_ENABLED) && clkSync && !clkPrev_reg;
    end else if (specialActive) begin
      opModeEff_next = SDM_OPMODE_VELOCITY;
      if (pState_reg == SDM_PS_ENABLED) begin
        // (RL17) fixed test speed, direction from code
        if (isTest) begin
          speed_next = (modeFn == SDM_FN_TEST_CW) ? $signed(SDM_TEST_RPM) : -$signed(SDM_TEST_RPM);
        end else begin
          speed_next = $signed(target_reg);
        end
      end
    end else if (opMode_reg == SDM_OPMODE_VELOCITY && pState_reg == SDM_PS_ENABLED) begin
      // (RL1) velocity from target register
      speed_next = $signed(target_reg);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pState_reg <= SDM_PS_DISABLED;
      opModeEff_reg <= SDM_RST_OPMODE;
      speed_reg <= 16'sh0000;
      clkPrev_reg <= 1'b0;
      step_reg <= 1'b0;
      stepDir_reg <= 1'b0;
    end else begin
      pState_reg <= pState_next;
      opModeEff_reg <= opModeEff_next;
      speed_reg <= speed_next;
      clkPrev_reg <= clkSync;
      step_reg <= step_next;
      stepDir_reg <= dirSync;
    end
  end

  assign opModeEff = opModeEff_reg;
  assign speedCmd = speed_reg;
  assign driveEnable = (pState_reg == SDM_PS_ENABLED);
  assign stepPulse = step_reg;
  assign stepDir = stepDir_reg;

  // ****************************************
  // Checks
  // ****************************************
  vel_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL1
    (!specialActive && opMode_reg == SDM_OPMODE_VELOCITY && pState_reg == SDM_PS_ENABLED)
    |=> speedCmd == $past(target_reg)) else $error("velocity speed not taken from target");
  stop_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL2
    (!specialActive && regWrite && regAddr == SDM_IDX_CTRL && regWdata == SDM_CTRL_STOP)
    |-> ##2 (pState_reg == SDM_PS_DISABLED) ##1 (speedCmd == 16'sh0000)) else $error("stop not obeyed");
  enable_only_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL4
    specialActive |=> driveEnable == $past(enSync)) else $error("power not following enable");
  release_stop_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL18
    (specialActive && !enSync) |=> ##1 speedCmd == 16'sh0000) else $error("motion after enable release");
  activate_code_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL6
    (started_reg && actEn_reg != SDM_SPECIAL_ON) |=> opModeEff == $past(opMode_reg))
    else $error("special mode active without code");
  restart_only_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL9
    (started_reg && regWrite && (regAddr == SDM_IDX_CFG_EN || regAddr == SDM_IDX_CFG_MODE))
    |=> $stable(actEn_reg) && $stable(actMode_reg)) else $error("configuration applied without restart");
  clkdir_force_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL10
    isClkDir |=> opModeEff == SDM_OPMODE_CLKDIR) else $error("clock-direction mode not forced");
  dead_zone_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL14
    (isAnalog && adcValid && adcData <= SDM_DEAD_CODES) |=> target_reg == 16'h0000)
    else $error("motion inside dead zone");
  joy_offset_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL15
    isJoy |=> aOffset_reg == 16'(SDM_ADC_MID)) else $error("joystick offset not set");
  scale_set_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL12
    (isAnalog || isJoy) |=> vScale_reg == $past(maxRpm)) else $error("scaling not matched");
  test_speed_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RL17
    (isTest && pState_reg == SDM_PS_ENABLED) |=> (speedCmd == 16'sh001e || speedCmd == -16'sh001e))
    else $error("test run speed wrong");

endmodule : sdm_control

// ===== sdm_far_side.sv
// Far-side model: nonvolatile configuration store and periodic analog sampler
`timescale 1ns/1ns
module sdm_far_side (
  input wire logic ref_clk,
  input wire logic nvSave,
  input wire logic [7:0] nvSaveEnable,
  input wire logic [3:0] nvSaveMode,
  output logic [7:0] nvCfgEnable,
  output logic [3:0] nvCfgMode,
  input wire logic [sdm_pkg::SDM_ADC_BITS-1:0] analogLevel,
  output logic [sdm_pkg::SDM_ADC_BITS-1:0] adcData,
  output logic adcValid
);
  import sdm_pkg::*;
  logic [3:0] sampleCnt = 4'h0;

  initial begin
    nvCfgEnable = 8'h00;
    nvCfgMode = 4'h0;
    adcValid = 1'b0;
    adcData = 12'h000;
  end

  // image kept across restarts
  // No reset input: storage must not forget when the controller restarts
  always @(posedge ref_clk) begin
    if (nvSave === 1'b1) begin
      nvCfgEnable <= nvSaveEnable;
      nvCfgMode <= nvSaveMode;
    end
    sampleCnt <= sampleCnt + 4'h1;
    adcValid <= (sampleCnt == 4'hf);
    // Between samples the bus carries junk, never a stale valid value
    adcData <= (sampleCnt == 4'hf) ? analogLevel : ~analogLevel;
  end
endmodule : sdm_far_side

// ===== test_sdm_control.sv
// Self-checking bench for the special drive mode control block
`timescale 1ns/1ns
module test_sdm_control;
  import sdm_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [15:0] regRdata;
  logic [3:0] digitalIn = 4'h0;
  logic clockIn = 1'b0;
  logic directionIn = 1'b0;
  logic [11:0] analogLevel = 12'h000;
  logic [11:0] adcData;
  logic adcValid;
  logic nvSave;
  logic [7:0] nvCfgEnable;
  logic [7:0] nvSaveEnable;
  logic [7:0] opModeEff;
  logic [3:0] nvCfgMode;
  logic [3:0] nvSaveMode;
  logic driveEnable;
  logic closedLoop;
  logic stepPulse;
  logic stepDir;
  logic signed [15:0] speedCmd;
  logic [15:0] rd;
  logic [15:0] old;
  int miscompares = 0;
  int nTests = 0;
  int pulses = 0;

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (stepPulse === 1'b1) pulses++;

  sdm_control DUT (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .digitalIn(digitalIn),
    .clockIn(clockIn), .directionIn(directionIn), .adcData(adcData), .adcValid(adcValid),
    .nvCfgEnable(nvCfgEnable), .nvCfgMode(nvCfgMode), .nvSave(nvSave), .nvSaveEnable(nvSaveEnable),
    .nvSaveMode(nvSaveMode), .opModeEff(opModeEff), .driveEnable(driveEnable), .closedLoop(closedLoop),
    .speedCmd(speedCmd), .stepPulse(stepPulse), .stepDir(stepDir));

  sdm_far_side FAR (.ref_clk(ref_clk), .nvSave(nvSave), .nvSaveEnable(nvSaveEnable),
    .nvSaveMode(nvSaveMode), .nvCfgEnable(nvCfgEnable), .nvCfgMode(nvCfgMode),
    .analogLevel(analogLevel), .adcData(adcData), .adcValid(adcValid));

  // ****************************************
  // Bus, pin and compare helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cycles

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rdreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask : rdreg

  task automatic pins(input logic [3:0] di, input logic dir);
    @(posedge ref_clk);
    digitalIn <= di;
    directionIn <= dir;
  endtask : pins

  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      clockIn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      clockIn <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    cycles(6);
  endtask : toggle

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic velocity_run();
    rdreg(SDM_IDX_VSCALE, rd);
    check(rd, 16'h0001, "scale reset value");
    rdreg(4'hf, rd);
    check(rd, 16'h0000, "unmapped read");
    wr(SDM_IDX_STATUS, 16'hffff);
    rdreg(SDM_IDX_STATUS, rd);
    check(rd, 16'h0000, "status is read-only");
    wr(SDM_IDX_OPMODE, 16'h0002);
    wr(SDM_IDX_TARGET, 16'h00c8);
    wr(SDM_IDX_CTRL, SDM_CTRL_READY);
    wr(SDM_IDX_CTRL, SDM_CTRL_ENABLE);
    cycles(4);
    check({8'h00, opModeEff}, 16'h0002, "velocity mode");
    check(speedCmd, 16'h00c8, "velocity speed");
    rdreg(SDM_IDX_STATUS, rd);
    check({15'h0000, rd[2]}, 16'h0001, "status op enabled");
    rdreg(SDM_IDX_SPEED, rd);
    check(rd, 16'h00c8, "speed readback");
    rdreg(SDM_IDX_OPMODE, rd);
    check(rd, 16'h0002, "mode readback");
    wr(SDM_IDX_CTRL, SDM_CTRL_STOP);
    cycles(4);
    check({15'h0000, driveEnable}, 16'h0000, "stop by zero word");
    check(speedCmd, 16'h0000, "stopped speed");
  endtask : velocity_run

  task automatic restart(input logic [7:0] en, input logic [3:0] code);
    rdreg(SDM_IDX_STATUS, old);
    wr(SDM_IDX_CFG_EN, {8'h00, en});
    wr(SDM_IDX_CFG_MODE, {12'h000, code});
    wr(SDM_IDX_SAVE, 16'h0001);
    #1;
    check({7'h00, nvSave, nvSaveEnable}, {8'h01, en}, "save strobe");
    check({12'h000, nvSaveMode}, {12'h000, code}, "saved mode");
    rdreg(SDM_IDX_STATUS, rd);
    check(rd & 16'h0f03, old & 16'h0f03, "config not live before restart");
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    cycles(3);
    rdreg(SDM_IDX_STATUS, rd);
    check({15'h0000, rd[0]}, {15'h0000, en == SDM_SPECIAL_ON}, "special flag");
    if (en == SDM_SPECIAL_ON) begin
      check({12'h000, rd[11:8]}, {12'h000, code}, "active mode code");
      check({15'h0000, closedLoop}, {15'h0000, code[3]}, "loop choice");
    end
  endtask : restart

  task automatic test_run(input logic ccw);
    pins(4'h7, 1'b0);
    wr(SDM_IDX_CTRL, SDM_CTRL_ENABLE);
    cycles(8);
    check({15'h0000, driveEnable}, 16'h0000, "control word ignored");
    pins(4'h8, 1'b0);
    cycles(8);
    check({15'h0000, driveEnable}, 16'h0001, "enable input");
    check(speedCmd, ccw ? 16'hffe2 : 16'h001e, "test run speed");
    rdreg(SDM_IDX_SPEED, rd);
    check(rd, ccw ? 16'hffe2 : 16'h001e, "test speed readback");
    wr(SDM_IDX_CTRL, SDM_CTRL_STOP);
    cycles(8);
    check({15'h0000, driveEnable}, 16'h0001, "stop word ignored");
    pins(4'h0, 1'b0);
    cycles(8);
    check({15'h0000, driveEnable}, 16'h0000, "enable dropped");
    check(speedCmd, 16'h0000, "motion stopped");
  endtask : test_run

  task automatic analog_run(input int vmax, input logic joy);
    logic [11:0] lv [6] = '{12'h008, 12'h009, 12'h800, 12'hfff, 12'h7f8, 12'h000};
    int e;
    int d;
    pins(4'h8, 1'b0);
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      analogLevel <= lv[i % 6];
      directionIn <= !joy && i >= 6;
      cycles(40);
      d = joy ? int'(lv[i % 6]) - 2048 : int'(lv[i % 6]);
      e = (d <= 8 && d >= -8) ? 0 : (d < 0 ? -d : d) * vmax / (joy ? 2048 : 4095);
      if (d < 0 || (!joy && i >= 6)) e = -e;
      check(speedCmd, 16'(e), "analog speed");
      rdreg(SDM_IDX_TARGET, rd);
      check(rd, 16'(e), "analog target");
    end
    check({8'h00, opModeEff}, 16'h0002, "analog velocity mode");
    rdreg(SDM_IDX_VSCALE, rd);
    check(rd, 16'(vmax), "scale follows maximum");
    rdreg(SDM_IDX_AOFFSET, rd);
    check(rd, joy ? 16'h0800 : 16'h0000, "joystick offset");
    pins(4'h0, 1'b0);
  endtask : analog_run

  task automatic clkdir_run();
    pins(4'h8, 1'b1);
    cycles(6);
    pulses = 0;
    toggle(3);
    check(16'(pulses), 16'h0003, "steps while enabled");
    check({15'h0000, stepDir}, 16'h0001, "step direction");
    check({8'h00, opModeEff}, 16'h00ff, "clock-direction mode");
    pins(4'h0, 1'b1);
    cycles(6);
    pulses = 0;
    toggle(2);
    check(16'(pulses), 16'h0000, "steps gated off");
  endtask : clkdir_run

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    cycles(3);
    velocity_run();
    restart(8'h01, 4'h2);
    wr(SDM_IDX_CTRL, SDM_CTRL_ENABLE);
    cycles(4);
    check({15'h0000, driveEnable}, 16'h0001, "word still works when inactive");
    wr(SDM_IDX_CTRL, SDM_CTRL_STOP);
    for (int c = 0; c < 16; c++) begin
      restart(SDM_SPECIAL_ON, 4'(c));
      case (c % 8)
        0, 1: clkdir_run();
        2, 3: test_run(c[0]);
        default: analog_run(c[0] ? 100 : 1000, c[1]);
      endcase
    end
    complete_run();
  end

  // Whole run needs about 5000 cycles; allow plenty before calling it hung
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
endmodule : test_sdm_control
